// *** rtl/map_ctrl_pkg.sv ***
package map_ctrl_pkg;

    // Register word offsets on the Avalon bus (byte addresses)
    localparam logic [7:0] RAM_POSITION_OFFSET = 8'h00;
    localparam logic [7:0] REGISTER_BLOCK_POSITION_OFFSET = 8'h04;
    localparam logic [7:0] NVDATA_POSITION_OFFSET = 8'h08;
    localparam logic [7:0] SYSTEM_OPTIONS_OFFSET = 8'h0C;
    localparam logic [7:0] TEST_RESERVED_ZERO_OFFSET = 8'h10;

    // Field positions shared by the position registers
    localparam int BASE_MSB = 7;
    localparam int BASE_LSB = 3;
    localparam int ALIGN_BIT = 0;
    localparam int NVDATA_ENABLE_BIT = 0;
    localparam int REG_BLOCK_ZERO_BIT = 7;

    // Field positions of the system options register
    localparam int STRETCH_MSB = 3;
    localparam int STRETCH_LSB = 2;
    localparam int UPPER_HALF_BIT = 1;
    localparam int ROM_ENABLE_BIT = 0;

    // Masks of implemented bits; the rest read as zero
    localparam logic [7:0] RAM_POSITION_MASK = 8'hF9;
    localparam logic [7:0] REGISTER_BLOCK_POSITION_MASK = 8'h78;
    localparam logic [7:0] NVDATA_POSITION_MASK = 8'hF9;
    localparam logic [7:0] SYSTEM_OPTIONS_MASK = 8'h0F;

    // Reset values
    localparam logic [7:0] RAM_POSITION_RESET = 8'h09;
    localparam logic [7:0] REGISTER_BLOCK_POSITION_RESET = 8'h00;
    localparam logic [7:0] NVDATA_POSITION_RESET = 8'h00;
    localparam logic [7:0] SYSTEM_OPTIONS_RESET = 8'h0C; // Stretch ones, ROM enable added
    localparam logic [7:0] TEST_RESERVED_ZERO_VALUE = 8'h00;
    localparam logic ROM_ENABLE_RESET_EXPANDED = 1'b1;

    // Integration option: nvdata base bits write-once outside special modes
    localparam logic NVDATA_BASE_WRITE_ONCE = 1'b0;

    // Bus answer timing: one wait cycle before each answer
    localparam int BUS_WAIT_CYCLES = 1;

endpackage

// *** rtl/memory_map_position_control.sv ***
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
// Overview of operation
// - RAM position readable; write once unless special
// - Map outputs change one cycle after write
// - RAM position bits 7:3 give RAM base
// - Bit 0 aligns RAM low or high
// - Register block position: write once unless special
// - Register block on 2K boundary, lowest 32K
// - Register block bit 7 reads constant zero
// - Nvdata enable always writable; base per option
// - Nvdata position bits 7:3 give nvdata base
// - Nvdata enable bit maps or unmaps nvdata
// - System options reset; ROM enable by mode
// - Stretch, half, ROM enable written once unless special
// - Stretch field gives zero to three clocks
// - Stretch ignored in single chip, peripheral
// - Upper half bit hides lower ROM pages
// - ROM enable bit maps or unmaps ROM
// - Test register reads zero, ignores writes
// - RAM position resets to 09 hex
module memory_map_position_control (
    input wire logic clock, // Core clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read request
    input wire logic write, // Avalon write request
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait request
    input wire logic special_mode, // Any special mode active
    input wire logic single_chip_mode, // Single chip or peripheral mode
    input wire logic special_test_mode, // Special test mode
    output logic [4:0] ram_base, // RAM base address bits 15:11
    output logic ram_high_align, // RAM against top of its region
    output logic [4:0] reg_base, // Register block base bits 15:11
    output logic [4:0] nvdata_base, // Nvdata base address bits 15:11
    output logic nvdata_map_enable, // Nvdata present in map
    output logic [1:0] stretch_cycles, // Clocks added to external access
    output logic rom_upper_half_only, // Lower half ROM pages hidden
    output logic lower_half_direct, // Lower half ROM pages reachable
    output logic rom_map_enable // ROM present in map
);

    typedef struct packed {
        logic [7:0] ram_pos;
        logic [7:0] reg_pos;
        logic [7:0] nv_pos;
        logic [7:0] sys_opt;
        logic ram_written;
        logic reg_written;
        logic nv_written;
        logic sys_written;
        logic waitrequest;
        logic [31:0] readdata;
        logic [4:0] ram_base;
        logic ram_high_align;
        logic [4:0] reg_base;
        logic [4:0] nv_base;
        logic nv_enable;
        logic [1:0] stretch_cycles;
        logic rom_upper_half_only;
        logic lower_half_direct;
        logic rom_map_enable;
    } state_s;

    state_s st;
    state_s next_st;

    // Write permission for a write-once field
    function automatic logic may_write(input logic written, input logic special);
        may_write = special | ~written;
    endfunction

    // Replace masked bits of an old value with new data
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction

    logic req;
    logic accept_wr;
    logic [7:0] wbyte;

    // A request is served once, in the cycle waitrequest is low
    assign req = read | write;
    assign accept_wr = write & ~st.waitrequest & byteenable[0];
    assign wbyte = writedata[7:0];

    // Next state: bus handshake, register writes, map outputs
    always_comb
    begin
        logic rom_reset;
        logic [7:0] sys_mask;
        logic [7:0] nv_mask;
        rom_reset = 1'b0;
        sys_mask = 8'h00;
        nv_mask = 8'h00;
        next_st = st;

        // One wait cycle, then a one-cycle answer
        next_st.waitrequest = ~(req & st.waitrequest);
        if (req & st.waitrequest)
        begin
            unique case (address)
                map_ctrl_pkg::RAM_POSITION_OFFSET: next_st.readdata = {24'h000000, st.ram_pos};
                map_ctrl_pkg::REGISTER_BLOCK_POSITION_OFFSET:
                    next_st.readdata = {24'h000000, st.reg_pos};
                map_ctrl_pkg::NVDATA_POSITION_OFFSET: next_st.readdata = {24'h000000, st.nv_pos};
                map_ctrl_pkg::SYSTEM_OPTIONS_OFFSET: next_st.readdata = {24'h000000, st.sys_opt};
                map_ctrl_pkg::TEST_RESERVED_ZERO_OFFSET:
                    next_st.readdata = {24'h000000, map_ctrl_pkg::TEST_RESERVED_ZERO_VALUE};
                default: next_st.readdata = 32'h00000000; // Unmapped reads as zero
            endcase
        end

        // Register writes; the written flag is set by any write
        if (accept_wr)
        begin
            unique case (address)
                map_ctrl_pkg::RAM_POSITION_OFFSET:
                begin
                    if (may_write(st.ram_written, special_mode))
                        next_st.ram_pos = wbyte & map_ctrl_pkg::RAM_POSITION_MASK;
                    next_st.ram_written = 1'b1;
                end
                map_ctrl_pkg::REGISTER_BLOCK_POSITION_OFFSET:
                begin
                    // Bit 7 masked off keeps the block under 32K
                    if (may_write(st.reg_written, special_mode))
                        next_st.reg_pos = wbyte & map_ctrl_pkg::REGISTER_BLOCK_POSITION_MASK;
                    next_st.reg_written = 1'b1;
                end
                map_ctrl_pkg::NVDATA_POSITION_OFFSET:
                begin
                    // Enable always writable; base bits by integration option
                    nv_mask = 8'h01;
                    if (!map_ctrl_pkg::NVDATA_BASE_WRITE_ONCE
                        || may_write(st.nv_written, special_mode))
                        nv_mask = map_ctrl_pkg::NVDATA_POSITION_MASK;
                    next_st.nv_pos = merge(st.nv_pos, wbyte, nv_mask);
                    next_st.nv_written = 1'b1;
                end
                map_ctrl_pkg::SYSTEM_OPTIONS_OFFSET:
                begin
                    sys_mask = may_write(st.sys_written, special_mode)
                        ? map_ctrl_pkg::SYSTEM_OPTIONS_MASK : 8'h00;
                    next_st.sys_opt = merge(st.sys_opt, wbyte, sys_mask);
                    next_st.sys_written = 1'b1;
                end
                default:
                begin
                    // Test register and unmapped offsets ignore writes
                    next_st.ram_written = st.ram_written;
                end
            endcase
        end

        // Map outputs follow the registers one cycle late
        next_st.ram_base = st.ram_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
        next_st.ram_high_align = st.ram_pos[map_ctrl_pkg::ALIGN_BIT];
        next_st.reg_base = st.reg_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
        next_st.nv_base = st.nv_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
        next_st.nv_enable = st.nv_pos[map_ctrl_pkg::NVDATA_ENABLE_BIT];
        // External stretch has no meaning without an external bus
        next_st.stretch_cycles = single_chip_mode ? 2'b00
            : st.sys_opt[map_ctrl_pkg::STRETCH_MSB:map_ctrl_pkg::STRETCH_LSB];
        next_st.rom_upper_half_only = st.sys_opt[map_ctrl_pkg::UPPER_HALF_BIT];
        next_st.lower_half_direct = ~st.sys_opt[map_ctrl_pkg::UPPER_HALF_BIT];
        next_st.rom_map_enable = st.sys_opt[map_ctrl_pkg::ROM_ENABLE_BIT];

        // Synchronous reset; ROM enable depends on mode at reset
        if (!rst_n)
        begin
            if (special_test_mode)
                rom_reset = 1'b0;
            else if (single_chip_mode)
                rom_reset = 1'b1;
            else
                rom_reset = map_ctrl_pkg::ROM_ENABLE_RESET_EXPANDED;
            next_st = '0;
            next_st.waitrequest = 1'b1;
            next_st.ram_pos = map_ctrl_pkg::RAM_POSITION_RESET;
            next_st.reg_pos = map_ctrl_pkg::REGISTER_BLOCK_POSITION_RESET;
            next_st.nv_pos = map_ctrl_pkg::NVDATA_POSITION_RESET;
            next_st.sys_opt = map_ctrl_pkg::SYSTEM_OPTIONS_RESET | {7'h00, rom_reset};
            next_st.ram_base = map_ctrl_pkg::RAM_POSITION_RESET[7:3];
            next_st.ram_high_align = map_ctrl_pkg::RAM_POSITION_RESET[0];
            next_st.reg_base = map_ctrl_pkg::REGISTER_BLOCK_POSITION_RESET[7:3];
            next_st.nv_base = map_ctrl_pkg::NVDATA_POSITION_RESET[7:3];
            next_st.nv_enable = map_ctrl_pkg::NVDATA_POSITION_RESET[0];
            next_st.stretch_cycles = single_chip_mode ? 2'b00
                : map_ctrl_pkg::SYSTEM_OPTIONS_RESET[3:2];
            next_st.lower_half_direct = 1'b1;
            next_st.rom_map_enable = rom_reset;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        st <= next_st;
    end

    // Outputs straight from the state flops
    assign readdata = st.readdata;
    assign waitrequest = st.waitrequest;
    assign ram_base = st.ram_base;
    assign ram_high_align = st.ram_high_align;
    assign reg_base = st.reg_base;
    assign nvdata_base = st.nv_base;
    assign nvdata_map_enable = st.nv_enable;
    assign stretch_cycles = st.stretch_cycles;
    assign rom_upper_half_only = st.rom_upper_half_only;
    assign lower_half_direct = st.lower_half_direct;
    assign rom_map_enable = st.rom_map_enable;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic ram_wr;
    logic reg_wr;
    logic nv_wr;
    logic sys_wr;
    logic test_wr;

    // Accepted writes per register, for the checks below
    assign ram_wr = accept_wr && address == map_ctrl_pkg::RAM_POSITION_OFFSET;
    assign reg_wr = accept_wr && address == map_ctrl_pkg::REGISTER_BLOCK_POSITION_OFFSET;
    assign nv_wr = accept_wr && address == map_ctrl_pkg::NVDATA_POSITION_OFFSET;
    assign sys_wr = accept_wr && address == map_ctrl_pkg::SYSTEM_OPTIONS_OFFSET;
    assign test_wr = accept_wr && address == map_ctrl_pkg::TEST_RESERVED_ZERO_OFFSET;

    // Field slices reused by the copy checks below
    logic [4:0] ram_field;
    logic [4:0] reg_field;
    logic [4:0] nv_field;
    logic [1:0] stretch_field;
    assign ram_field = st.ram_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
    assign reg_field = st.reg_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
    assign nv_field = st.nv_pos[map_ctrl_pkg::BASE_MSB:map_ctrl_pkg::BASE_LSB];
    assign stretch_field = st.sys_opt[map_ctrl_pkg::STRETCH_MSB:map_ctrl_pkg::STRETCH_LSB];

    sequence s_ram_write;
        ram_wr && (special_mode || !st.ram_written);
    endsequence

    sequence s_ram_map_late;
        $stable(ram_base) ##1 (ram_base == $past(st.ram_pos[7:3]));
    endsequence

    a_ram_write_once: assert property (ram_wr && !special_mode && st.ram_written |=> $stable(st.ram_pos))
        else $error("RAM position changed on a second write");

    a_ram_special_write: assert property (ram_wr && special_mode |=> st.ram_pos == ($past(wbyte) & 8'hF9))
        else $error("RAM position missed a special mode write");

    a_map_one_late: assert property (s_ram_write |=> s_ram_map_late)
        else $error("RAM base did not follow one cycle after the write");

    a_reg_once: assert property (reg_wr && !special_mode && st.reg_written |=> $stable(st.reg_pos))
        else $error("Register block position changed on a second write");

    a_reg_under_32k: assert property (reg_wr |=> ##1 !reg_base[4] && !st.reg_pos[7])
        else $error("Register block base left the lowest 32K");

    a_nv_enable_any: assert property (nv_wr |=> st.nv_pos[0] == $past(wbyte[0]) ##1 nvdata_map_enable == st.nv_pos[0])
        else $error("Nvdata enable write not taken or not mapped");

    a_sys_once: assert property (sys_wr && !special_mode && st.sys_written |=> $stable(st.sys_opt))
        else $error("System options changed on a second write");

    a_stretch_single: assert property (single_chip_mode[*2] |-> stretch_cycles == 2'b00)
        else $error("Stretch active in single chip mode");

    a_half_polarity: assert property (##1 lower_half_direct == !rom_upper_half_only)
        else $error("Lower half access polarity wrong");

    a_test_no_effect: assert property (test_wr |=> $stable(st.ram_pos) && $stable(st.sys_opt) && $stable(st.nv_pos))
        else $error("Test register write changed state");

    a_reset_values: assert property (disable iff (1'b0) !rst_n |=> st.ram_pos == 8'h09 && st.sys_opt[7:1] == 7'h06)
        else $error("Wrong reset value");

    a_bus_answer: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer not one wait cycle");

    // Map outputs are one-cycle copies of the register fields; stretch is forced to zero in single chip mode
    a_ram_base_copy: assert property (ram_base == $past(ram_field))
        else $error("RAM base is not the registered field");

    a_ram_align_copy: assert property (
        ram_high_align == $past(st.ram_pos[map_ctrl_pkg::ALIGN_BIT]))
        else $error("RAM alignment is not the registered bit");

    a_reg_base_copy: assert property (reg_base == $past(reg_field))
        else $error("Register block base is not the registered field");

    a_nv_base_copy: assert property (nvdata_base == $past(nv_field))
        else $error("Nvdata base is not the registered field");

    a_nv_enable_copy: assert property (
        nvdata_map_enable == $past(st.nv_pos[map_ctrl_pkg::NVDATA_ENABLE_BIT]))
        else $error("Nvdata enable is not the registered bit");

    a_stretch_copy: assert property (
        !$past(single_chip_mode) |-> stretch_cycles == $past(stretch_field))
        else $error("Stretch output differs from its field");

    a_stretch_off: assert property ($past(single_chip_mode) |-> stretch_cycles == 2'b00)
        else $error("Stretch not forced off in single chip mode");

    a_half_copy: assert property (
        rom_upper_half_only == $past(st.sys_opt[map_ctrl_pkg::UPPER_HALF_BIT]))
        else $error("Upper half bit is not the registered bit");

    a_rom_copy: assert property (
        rom_map_enable == $past(st.sys_opt[map_ctrl_pkg::ROM_ENABLE_BIT]))
        else $error("ROM enable is not the registered bit");

    // First writes land in every mode
    a_ram_first: assert property (
        ram_wr && !st.ram_written |=> st.ram_pos == ($past(wbyte) & 8'hF9))
        else $error("RAM position missed its first write");

    a_reg_first: assert property (
        reg_wr && !st.reg_written |=> st.reg_pos == ($past(wbyte) & 8'h78))
        else $error("Register block position missed its first write");

    a_reg_special: assert property (
        reg_wr && special_mode |=> st.reg_pos == ($past(wbyte) & 8'h78))
        else $error("Register block position missed a special mode write");

    a_reg_zero_bit: assert property (
        !st.reg_pos[map_ctrl_pkg::REG_BLOCK_ZERO_BIT])
        else $error("Register block top bit is set");

    a_nv_base_open: assert property (
        nv_wr && !map_ctrl_pkg::NVDATA_BASE_WRITE_ONCE
        |=> st.nv_pos == ($past(wbyte) & 8'hF9))
        else $error("Nvdata position missed a write");

    a_sys_first: assert property (
        sys_wr && !st.sys_written |=> st.sys_opt == ($past(wbyte) & 8'h0F))
        else $error("System options missed its first write");

    a_sys_special: assert property (
        sys_wr && special_mode |=> st.sys_opt == ($past(wbyte) & 8'h0F))
        else $error("System options missed a special mode write");

    // ROM enable at reset depends on the mode seen during reset
    a_rom_reset_test: assert property (disable iff (1'b0)
        !rst_n && special_test_mode |=> !st.sys_opt[map_ctrl_pkg::ROM_ENABLE_BIT])
        else $error("ROM enabled after reset in special test mode");

    a_rom_reset_other: assert property (disable iff (1'b0)
        !rst_n && !special_test_mode |=> st.sys_opt[map_ctrl_pkg::ROM_ENABLE_BIT])
        else $error("ROM disabled after reset outside special test mode");

    a_ram_flag_set: assert property (ram_wr |=> st.ram_written)
        else $error("RAM written flag not set");

    a_sys_flag_set: assert property (sys_wr |=> st.sys_written)
        else $error("System options written flag not set");

    // Read answers stand in the cycle waitrequest is low
    a_read_test_zero: assert property (
        read && !waitrequest && address == map_ctrl_pkg::TEST_RESERVED_ZERO_OFFSET
        |-> readdata == 32'h00000000)
        else $error("Test register did not read zero");

    a_read_ram: assert property (
        read && !waitrequest && address == map_ctrl_pkg::RAM_POSITION_OFFSET
        |-> readdata == {24'h000000, st.ram_pos})
        else $error("RAM position read wrong");

    a_readdata_upper: assert property (readdata[31:8] == 24'h000000)
        else $error("Upper read data bits not zero");

    a_idle_wait: assert property (!$past(req) |-> waitrequest)
        else $error("Waitrequest low without a request");

    // A write without the low lane is answered but changes nothing
    a_lane_ignored: assert property (write && !waitrequest && !byteenable[0]
        |=> $stable(st.ram_pos) && $stable(st.reg_pos) && $stable(st.sys_opt))
        else $error("Write without low lane changed state");

endmodule

// *** bench/cpu_bus_model.sv ***
`timescale 1ns/10ps
module cpu_bus_model (
    input wire logic clock, // Core clock
    output logic [7:0] address, // Request address
    output logic read, // Read strobe
    output logic write, // Write strobe
    output logic [31:0] writedata, // Write data
    output logic [3:0] byteenable, // Byte lanes
    input wire logic [31:0] readdata, // Answer data
    input wire logic waitrequest, // Slave stall
    output int hang_count // Requests never answered
);
    // Idle bus from time zero
    initial
    begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        hang_count = 0;
    end

    // One transfer; held until waitrequest is seen low at a rising edge or 50 edges pass
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] rdata);
        int n;
        begin
            n = 0;
            @(posedge clock);
            address <= a;
            read <= !wr;
            write <= wr;
            writedata <= d;
            byteenable <= be;
            do
            begin
                @(posedge clock);
                n++;
            end
            while (waitrequest !== 1'b0 && n < 50);
            if (n >= 50)
                hang_count++;
            rdata = readdata;
            read <= 1'b0;
            write <= 1'b0;
            // Released lines flip so stale values never look current
            address <= ~a;
            writedata <= ~d;
        end
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic clock;
    logic rst_n;
    logic special_mode;
    logic single_chip_mode;
    logic special_test_mode;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic [4:0] ram_base;
    logic ram_high_align;
    logic [4:0] reg_base;
    logic [4:0] nvdata_base;
    logic nvdata_map_enable;
    logic [1:0] stretch_cycles;
    logic rom_upper_half_only;
    logic lower_half_direct;
    logic rom_map_enable;
    logic [21:0] map_seen;
    int hang_count;
    int fail_count;
    int total_checks;
    logic [7:0] m_ram, m_reg, m_nv, m_sys;
    logic [3:0] done_once;

    memory_map_position_control u_dut (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .special_mode(special_mode),
        .single_chip_mode(single_chip_mode), .special_test_mode(special_test_mode),
        .ram_base(ram_base), .ram_high_align(ram_high_align), .reg_base(reg_base),
        .nvdata_base(nvdata_base), .nvdata_map_enable(nvdata_map_enable),
        .stretch_cycles(stretch_cycles), .rom_upper_half_only(rom_upper_half_only),
        .lower_half_direct(lower_half_direct), .rom_map_enable(rom_map_enable));

    cpu_bus_model u_cpu (.clock(clock), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .hang_count(hang_count));

    // All map outputs in one word for comparison
    assign map_seen = {ram_base, ram_high_align, reg_base, nvdata_base, nvdata_map_enable,
        stretch_cycles, rom_upper_half_only, lower_half_direct, rom_map_enable};

    // Core clock, 100 MHz
    always #5 clock = ~clock;

    function automatic logic [21:0] exp_map(input logic sc);
        return {m_ram[7:3], m_ram[0], m_reg[7:3], m_nv[7:3], m_nv[0],
            sc ? 2'b00 : m_sys[3:2], m_sys[1], !m_sys[1], m_sys[0]};
    endfunction

    function automatic logic [31:0] exp_read(input logic [7:0] a);
        case (a)
            8'h00: return {24'h000000, m_ram};
            8'h04: return {24'h000000, m_reg};
            8'h08: return {24'h000000, m_nv};
            8'h0C: return {24'h000000, m_sys};
            default: return 32'h00000000;
        endcase
    endfunction

    task automatic check_reg(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch readdata expected %h seen %h", exp, got);
        end
    endtask

    task automatic check_map(input logic [21:0] exp);
        total_checks++;
        if (map_seen !== exp)
        begin
            fail_count++;
            $display("mismatch map outputs expected %h seen %h", exp, map_seen);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Reset for 12 cycles and load the expected reset image
    task automatic do_reset(input logic tm);
        rst_n <= 1'b0;
        special_test_mode <= tm;
        single_chip_mode <= 1'b0;
        special_mode <= 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        m_ram = 8'h09;
        m_reg = 8'h00;
        m_nv = 8'h00;
        m_sys = {7'h06, !tm};
        done_once = 4'h0;
        @(posedge clock);
    endtask

    // Write and track what the block should now hold
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] data;
        logic [31:0] unused;
        begin
            data = $urandom;
            data[7:0] = d;
            u_cpu.access(1'b1, a, data, be, unused);
            if (be[0] && a < 8'h10)
            begin
                if (a == 8'h08 || special_mode || !done_once[a[3:2]])
                    case (a[3:2])
                        2'd0: m_ram = d & 8'hF9;
                        2'd1: m_reg = d & 8'h78;
                        2'd2: m_nv = d & 8'hF9;
                        default: m_sys = d & 8'h0F;
                    endcase
                done_once[a[3:2]] = 1'b1;
            end
        end
    endtask

    // Read every offset, one unmapped, then the map outputs
    task automatic sweep();
        logic [31:0] got;
        begin
            for (int i = 0; i < 6; i++)
            begin
                u_cpu.access(1'b0, 8'(i * 4), 32'h0, 4'hF, got);
                check_reg(exp_read(8'(i * 4)), got);
            end
            check_map(exp_map(single_chip_mode));
        end
    endtask

    // Three phases: normal, special, special test
    initial
    begin
        logic [21:0] prev;
        logic [7:0] a;
        logic [3:0] be;
        int seed;
        clock = 1'b0;
        rst_n = 1'b0;
        special_mode = 1'b0;
        single_chip_mode = 1'b0;
        special_test_mode = 1'b0;
        fail_count = 0;
        total_checks = 0;
        seed = $urandom(32'h9571);
        for (int p = 0; p < 3; p++)
        begin
            do_reset(p == 2);
            special_mode <= (p != 0);
            sweep();
            prev = exp_map(1'b0);
            wr(8'h00, ~m_ram, 4'h1);
            @(negedge clock);
            check_map(prev);
            @(negedge clock);
            check_map(exp_map(1'b0));
            repeat (40)
            begin
                single_chip_mode <= 1'($urandom_range(0, 1));
                a = 8'($urandom_range(0, 5) * 4);
                be = ($urandom_range(0, 5) == 0) ? 4'hE : 4'h1;
                wr(a, 8'($urandom), be);
                if ($urandom_range(0, 3) == 0)
                    sweep();
            end
            sweep();
        end
        check_reg(32'h0, 32'(hang_count));
        give_verdict();
    end

    // Watchdog far beyond the expected run length
    initial
    begin
        #500000;
        fail_count++;
        give_verdict();
    end
endmodule
